// ---- ewp_pkg.sv ----
// Shared constants and types of the write-protect and ID page target
package ewp_pkg;
    // ========================================
    // Protection register layout
    localparam logic [7:0] WPC_RST = 8'h00;
    localparam int BIT_ACT = 3;
    localparam int BIT_BS_HI = 2;
    localparam int BIT_BS_LO = 1;
    localparam int BIT_LOCK = 0;
    // ========================================
    // Address selectors and ID page
    localparam logic [2:0] SEL_WPC = 3'h5;
    localparam logic [2:0] SEL_IDP = 3'h0;
    localparam int IDP_DEPTH = 128;
    localparam logic [7:0] IDP_BLANK = 8'hff;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [1:0] NB_ONE = 2'h1;
    localparam logic [1:0] NB_MAX = 2'h3;
    // ========================================
    // Types
    typedef enum {ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WR, ST_RD, ST_SKIP} ewp_st_e;
    typedef enum logic [1:0] {TGT_ARR, TGT_WPC, TGT_IDP, TGT_OTHER} ewp_tgt_e;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } ewp_arr_s;
endpackage

// ---- ewp_core.sv ----
// Two-wire target with write-protect register, array gating and ID page
// Functional notes
// - Register uses the special device-type code
// - First address top bits 101 select register
// - Other register address bits are ignored
// - Register read/write reuse array sequences
// - Register value restored at power-up
// - Multi-byte register write is abandoned
// - Locked: address acked, data not acked
// - Inhibit pin high refuses register writes
// - Lock bit returns to zero only when reset loads it from nv_wpc_i
// - Unlocked write updates bits 3..0 together
// - Layout activate, size hi/lo, lock; reserved zero
// - Activate bit enables region protection
// - Size code picks quarter, half, 3/4, all
// - Factory value is all zeros
// - Unlimited updates while unlocked
// - ID page selected by special code, 000
// - ID byte index from bits 6..0
// - ID page reuses array sequences
// - Locked ID page: data not acked
// - Blank ID page reads all ones
// - Protected or inhibited array write refused
// - Stop after write starts write cycle
// - Select byte bit 0 gives direction
// - Select bits 3..1 must match chip address
`timescale 1ns/100ps
module ewp_core #(
    parameter logic [3:0] DT_MEM = 4'h5,  // Arbitrary value
    parameter logic [3:0] DT_SPEC = 4'h6  // Arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic write_inhibit_pin_i,
    input wire logic [2:0] chip_address_config_i,
    input wire logic [3:0] nv_wpc_i,
    input wire logic idp_locked_i,
    input wire logic [7:0] arr_rdata_i,
    output ewp_pkg::ewp_arr_s arr_req_o,
    output logic write_cycle_o,
    output logic [7:0] write_protect_config_o,
    output logic wpc_store_o
);
    import ewp_pkg::*;

    // ========================================
    // Pin synchronisers
    logic [2:0] sy1_ff, sy2_ff;
    logic [1:0] sy3_ff;
    logic [2:0] pins;
    assign pins = {write_inhibit_pin_i, sda_i, scl_i};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    sy1_ff[g] <= 1'b1;
                    sy2_ff[g] <= 1'b1;
                end else if (ce_i) begin
                    sy1_ff[g] <= pins[g];
                    sy2_ff[g] <= sy1_ff[g];
                end
            end
        end
    endgenerate
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sy3_ff <= 2'h3;
        end else if (ce_i) begin
            sy3_ff <= sy2_ff[1:0];
        end
    end
    logic scl_s, sda_s, wc_s, rise, fall, start, stop;
    assign scl_s = sy2_ff[0];
    assign sda_s = sy2_ff[1];
    assign wc_s = sy2_ff[2];
    assign rise = scl_s && !sy3_ff[0];
    assign fall = !scl_s && sy3_ff[0];
    assign start = scl_s && sy3_ff[0] && !sda_s && sy3_ff[1];
    assign stop = scl_s && sy3_ff[0] && sda_s && !sy3_ff[1];

    // ========================================
    // State
    ewp_st_e st_ff, nxt_st;
    ewp_tgt_e tgt_ff, nxt_tgt;
    logic [3:0] cnt_ff, nxt_cnt, wpc_ff, nxt_wpc;
    logic [7:0] sh_ff, nxt_sh, hi_ff, nxt_hi, pend_ff, nxt_pend;
    logic [15:0] ptr_ff, nxt_ptr;
    logic [1:0] nb_ff, nxt_nb;
    logic slot_ff, nxt_slot, drv_ff, nxt_drv, rw_ff, nxt_rw;
    logic wd_ff, nxt_wd, more_ff, nxt_more, awr_ff, nxt_awr;
    logic cyc_ff, nxt_cyc, wps_ff, nxt_wps, id_we;
    logic [7:0] idm [IDP_DEPTH];
    logic [IDP_DEPTH-1:0] idv_ff;
    logic [7:0] rd_byte;
    logic prot, acc, sel_ok;

    // Upper quarters: codes 00..11 protect from 0xc000, 0x8000, 0x4000, 0x0000
    assign prot = wpc_ff[BIT_ACT]
        && (ptr_ff[15:14] >= ~wpc_ff[BIT_BS_HI:BIT_BS_LO]);
    assign sel_ok = (sh_ff[7:4] == DT_MEM || sh_ff[7:4] == DT_SPEC)
        && sh_ff[3:1] == chip_address_config_i;

    always_comb begin
        case (tgt_ff)
            TGT_WPC: rd_byte = {4'h0, wpc_ff};
            TGT_IDP: rd_byte = idv_ff[ptr_ff[6:0]] ? idm[ptr_ff[6:0]] : IDP_BLANK;
            TGT_ARR: rd_byte = arr_rdata_i;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        case (tgt_ff)
            TGT_ARR: acc = !wc_s && !prot;
            TGT_WPC: acc = !wc_s && !wpc_ff[BIT_LOCK];
            TGT_IDP: acc = !idp_locked_i;
            default: acc = 1'b0;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_tgt = tgt_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_hi = hi_ff;
        nxt_pend = pend_ff;
        nxt_ptr = ptr_ff;
        nxt_nb = nb_ff;
        nxt_slot = slot_ff;
        nxt_drv = drv_ff;
        nxt_rw = rw_ff;
        nxt_wd = wd_ff;
        nxt_more = more_ff;
        nxt_wpc = wpc_ff;
        nxt_awr = 1'b0;
        nxt_cyc = 1'b0;
        nxt_wps = 1'b0;
        id_we = 1'b0;
        if (start) begin
            nxt_st = ST_DEV;
            nxt_cnt = 4'h0;
            nxt_slot = 1'b0;
            nxt_drv = 1'b0;
            nxt_wd = 1'b0;
        end else if (stop) begin
            nxt_st = ST_IDLE;
            nxt_slot = 1'b0;
            nxt_drv = 1'b0;
            nxt_wd = 1'b0;
            if (st_ff == ST_WR && wd_ff) begin
                // Only a single-byte write reaches the register; more bytes drop the cycle
                if (tgt_ff != TGT_WPC) begin
                    nxt_cyc = 1'b1;
                end else if (nb_ff == NB_ONE) begin
                    nxt_cyc = 1'b1;
                    nxt_wpc = pend_ff[3:0];
                    nxt_wps = 1'b1;
                end
            end
        end else if (rise) begin
            if (slot_ff) begin
                if (st_ff == ST_RD) begin
                    nxt_more = !sda_s;
                    if (!sda_s) begin
                        nxt_ptr = (tgt_ff == TGT_ARR) ? ptr_ff + 16'h1
                            : {ptr_ff[15:7], ptr_ff[6:0] + 7'h1};
                    end
                end
            end else if (cnt_ff < BITS_BYTE && st_ff != ST_IDLE && st_ff != ST_SKIP) begin
                nxt_cnt = cnt_ff + 4'h1;
                if (st_ff != ST_RD) begin
                    nxt_sh = {sh_ff[6:0], sda_s};
                end
            end
        end else if (fall) begin
            // The clock rise ahead of a stop must not end the tenth-bit window
            nxt_wd = 1'b0;
            if (slot_ff) begin
                nxt_slot = 1'b0;
                nxt_drv = 1'b0;
                nxt_cnt = 4'h0;
                case (st_ff)
                    ST_DEV: nxt_st = rw_ff ? ST_RD : ST_AHI;
                    ST_AHI: nxt_st = ST_ALO;
                    ST_ALO: nxt_st = ST_WR;
                    ST_WR: begin
                        nxt_wd = 1'b1;
                        if (tgt_ff != TGT_WPC) begin
                            nxt_ptr = {ptr_ff[15:7], ptr_ff[6:0] + 7'h1};
                        end
                    end
                    ST_RD: nxt_st = more_ff ? ST_RD : ST_SKIP;
                    default: nxt_st = ST_SKIP;
                endcase
                if ((st_ff == ST_DEV && rw_ff) || (st_ff == ST_RD && more_ff)) begin
                    nxt_sh = rd_byte;
                    nxt_drv = !rd_byte[7];
                end
            end else if (cnt_ff == BITS_BYTE) begin
                nxt_slot = 1'b1;
                nxt_drv = 1'b1;
                case (st_ff)
                    ST_DEV: begin
                        nxt_rw = sh_ff[0];
                        if (!sel_ok) begin
                            nxt_st = ST_SKIP;
                            nxt_slot = 1'b0;
                            nxt_drv = 1'b0;
                        end else if (!sh_ff[0]) begin
                            nxt_tgt = (sh_ff[7:4] == DT_MEM) ? TGT_ARR : TGT_OTHER;
                        end
                    end
                    ST_AHI: nxt_hi = sh_ff;
                    ST_ALO: begin
                        nxt_nb = 2'h0;
                        if (tgt_ff == TGT_ARR) begin
                            nxt_ptr = {hi_ff, sh_ff};
                        end else if (hi_ff[7:5] == SEL_WPC) begin
                            nxt_tgt = TGT_WPC;
                        end else if (hi_ff[7:5] == SEL_IDP) begin
                            nxt_tgt = TGT_IDP;
                            nxt_ptr = {9'h000, sh_ff[6:0]};
                        end else begin
                            nxt_tgt = TGT_OTHER;
                        end
                    end
                    ST_WR: begin
                        if (acc) begin
                            nxt_nb = (nb_ff == NB_MAX) ? NB_MAX : nb_ff + 2'h1;
                            nxt_awr = (tgt_ff == TGT_ARR);
                            id_we = (tgt_ff == TGT_IDP);
                            if (nb_ff == 2'h0) begin
                                nxt_pend = sh_ff;
                            end
                        end else begin
                            // Refused data byte: no ack, pointer untouched
                            nxt_st = ST_SKIP;
                            nxt_slot = 1'b0;
                            nxt_drv = 1'b0;
                        end
                    end
                    ST_RD: nxt_drv = 1'b0;
                    default: begin
                        nxt_slot = 1'b0;
                        nxt_drv = 1'b0;
                    end
                endcase
            end else if (st_ff == ST_RD && cnt_ff != 4'h0) begin
                nxt_sh = {sh_ff[6:0], 1'b0};
                nxt_drv = !sh_ff[6];
            end
        end
        // Lock stays set once programmed
        nxt_wpc[BIT_LOCK] = nxt_wpc[BIT_LOCK] | wpc_ff[BIT_LOCK];
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_ff <= ST_IDLE;
            tgt_ff <= TGT_ARR;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            hi_ff <= 8'h00;
            pend_ff <= 8'h00;
            ptr_ff <= 16'h0000;
            nb_ff <= 2'h0;
            slot_ff <= 1'b0;
            drv_ff <= 1'b0;
            rw_ff <= 1'b0;
            wd_ff <= 1'b0;
            more_ff <= 1'b0;
            awr_ff <= 1'b0;
            cyc_ff <= 1'b0;
            wps_ff <= 1'b0;
            wpc_ff <= nv_wpc_i;
            idv_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
            tgt_ff <= nxt_tgt;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            hi_ff <= nxt_hi;
            pend_ff <= nxt_pend;
            ptr_ff <= nxt_ptr;
            nb_ff <= nxt_nb;
            slot_ff <= nxt_slot;
            drv_ff <= nxt_drv;
            rw_ff <= nxt_rw;
            wd_ff <= nxt_wd;
            more_ff <= nxt_more;
            awr_ff <= nxt_awr;
            cyc_ff <= nxt_cyc;
            wps_ff <= nxt_wps;
            wpc_ff <= nxt_wpc;
            if (id_we) begin
                idv_ff[ptr_ff[6:0]] <= 1'b1;
            end
        end
    end

    // ID page bytes are written as each is acked; no page staging buffer
    always_ff @(posedge sys_clk_i) begin
        if (ce_i && id_we) begin
            idm[ptr_ff[6:0]] <= sh_ff;
        end
    end

    // ========================================
    // Outputs
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !drv_ff;
    assign arr_req_o = '{wr: awr_ff, addr: ptr_ff, data: sh_ff};
    assign write_cycle_o = cyc_ff;
    assign wpc_store_o = wps_ff;
    assign write_protect_config_o = {4'h0, wpc_ff};

    // ========================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_data_end;
        ce_i && fall && !slot_ff && cnt_ff == BITS_BYTE && st_ff == ST_WR && !start && !stop;
    endsequence
    sequence s_wpc_refused;
        s_data_end ##0 (tgt_ff == TGT_WPC && (wpc_ff[BIT_LOCK] || wc_s));
    endsequence

    AST_LOCK_STICKY: assert property (wpc_ff[BIT_LOCK] |=> wpc_ff[BIT_LOCK])
        else $error("lock bit cleared");
    AST_RESV_ZERO: assert property (write_protect_config_o[7:4] == 4'h0)
        else $error("reserved bits not zero");
    AST_ONE_BYTE: assert property (wps_ff |-> $past(nb_ff) == NB_ONE)
        else $error("register updated after multi-byte write");
    AST_WPC_NOACK: assert property (s_wpc_refused |=> !drv_ff && st_ff == ST_SKIP)
        else $error("refused register data was acked");
    AST_WPC_HOLD: assert property (
        s_wpc_refused |=> !wps_ff && !wd_ff && nb_ff == $past(nb_ff))
        else $error("refused register write stored");
    AST_ARR_GATE: assert property (awr_ff |-> $past(!prot && !wc_s))
        else $error("array write in protected region");
    AST_CYCLE_STOP: assert property (cyc_ff |-> $past(stop) && $past(st_ff) == ST_WR)
        else $error("write cycle without stop");
    AST_QUARTER: assert property (
        (wpc_ff[3:1] == 3'b100) |-> prot == (ptr_ff[15:14] == 2'b11))
        else $error("upper quarter map wrong");
    AST_SEL_MATCH: assert property (
        (slot_ff && st_ff == ST_DEV) |-> $past(sh_ff[3:1]) == $past(chip_address_config_i))
        else $error("select acked on address mismatch");
    AST_ID_BLANK: assert property (
        (tgt_ff == TGT_IDP && !idv_ff[ptr_ff[6:0]]) |-> rd_byte == IDP_BLANK)
        else $error("blank ID byte not all ones");
endmodule

// ---- ewp_i2c_ctrl.sv ----
// Two-wire bus controller model facing the protect target
`timescale 1ns/100ps
module ewp_i2c_ctrl (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic res_v_o,
    output logic [7:0] res_d_o
);
    // ========================================
    // Idle bus: clock parked high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        res_v_o = 1'b0;
        res_d_o = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // Phases of 4 clocks keep setup and hold at 4 clocks past the synchronisers
    task automatic bit_io(input logic b, output logic s);
        w(4);
        sda_o = b;
        w(4);
        scl_o = 1'b1;
        w(4);
        s = sda_i;
        w(4);
        scl_o = 1'b0;
    endtask
    // Data a is set in the low phase, then moves to b while the clock is high
    task automatic cond(input logic a, input logic b);
        w(4);
        sda_o = a;
        w(4);
        scl_o = 1'b1;
        w(8);
        sda_o = b;
        w(8);
    endtask
    task automatic start();
        cond(1'b1, 1'b0);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        cond(1'b0, 1'b1);
    endtask
    task automatic post(input logic [7:0] d);
        res_d_o = d;
        res_v_o = 1'b1;
        w(1);
        res_v_o = 1'b0;
    endtask
    // Result is 1 when the target pulled the ninth bit low
    task automatic wbyte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        post({7'h00, ~s});
    endtask
    // Acknowledge withheld on the last byte so the target lets go of the line
    task automatic rbyte(input logic last);
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, s);
        post(d);
    endtask
endmodule

// ---- eeprom_write_protect_idpage_tb_top.sv ----
// Self-checking bench for the write-protect and ID page target
`timescale 1ns/100ps
module eeprom_write_protect_idpage_tb_top;
    import ewp_pkg::*;
    // ========================================
    // Clock, pins and bookkeeping
    localparam logic [3:0] T_MEM = 4'h5;  // Arbitrary value
    localparam logic [3:0] T_SPC = 4'h6;  // Arbitrary value
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic inh = 1'b0;
    logic idp_lk = 1'b0;
    logic [2:0] chip = 3'h0;
    logic [3:0] nv = 4'h0;
    logic scl, m_sda, sda_o, oe_n, wcyc, st, rv;
    logic [7:0] cfg, rd, last_d;
    logic [15:0] last_a;
    ewp_arr_s arr;
    wire logic sda = oe_n ? m_sda : (m_sda & sda_o);
    logic [7:0] q[$];
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_wr = 0;
    int n_wc = 0;
    int n_st = 0;
    int seed = 32'h834aa405;
    always #12.5 sys_clk_i = ~sys_clk_i;
    ewp_core #(.DT_MEM(T_MEM), .DT_SPEC(T_SPC)) dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(oe_n), .write_inhibit_pin_i(inh),
        .chip_address_config_i(chip), .nv_wpc_i(nv), .idp_locked_i(idp_lk),
        .arr_rdata_i(arr.addr[7:0] ^ 8'h5a), .arr_req_o(arr), .write_cycle_o(wcyc),
        .write_protect_config_o(cfg), .wpc_store_o(st));
    ewp_i2c_ctrl m (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda),
        .res_v_o(rv), .res_d_o(rd));
    // ========================================
    // Comparison, verdict and the watching process
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (rv) begin
            check("bus", {8'h00, rd}, {8'h00, q.pop_front()});
        end
        if (arr.wr === 1'b1) begin
            n_wr++;
            last_a = arr.addr;
            last_d = arr.data;
        end
        if (wcyc === 1'b1) n_wc++;
        if (st === 1'b1) n_st++;
        // Whole plan is near 17k cycles; 60000, about three and a half times that, means a hang
        if (cyc == 60000) begin
            failures++;
            conclude();
        end
    end
    // ========================================
    // Transfers: each byte notes its expected result first
    function automatic logic [7:0] sel(input logic [3:0] t, input logic r);
        return {t, chip, r};
    endfunction
    task automatic wb(input logic [7:0] d, input logic e);
        q.push_back({7'h00, e});
        m.wbyte(d);
    endtask
    task automatic hdr(input logic [3:0] t, input logic [15:0] a);
        m.start();
        wb(sel(t, 1'b0), 1'b1);
        wb(a[15:8], 1'b1);
        wb(a[7:0], 1'b1);
    endtask
    task automatic wr1(input logic [3:0] t, input logic [15:0] a, input logic [7:0] d,
                       input logic e);
        int b_wr, b_wc, b_st;
        b_wr = n_wr;
        b_wc = n_wc;
        b_st = n_st;
        hdr(t, a);
        wb(d, e);
        m.stop();
        check("wcyc", 16'(n_wc - b_wc), {15'h0, e});
        if (t == T_MEM) check("arr_wr", 16'(n_wr - b_wr), {15'h0, e});
        if (t == T_MEM && e) check("arr_addr", last_a, a);
        if (t == T_MEM && e) check("arr_data", {8'h00, last_d}, {8'h00, d});
        if (t == T_SPC && a[15:13] == SEL_WPC) check("store", 16'(n_st - b_st), {15'h0, e});
    endtask
    task automatic rd1(input logic [3:0] t, input logic [15:0] a, input logic [7:0] e);
        hdr(t, a);
        m.start();
        wb(sel(t, 1'b1), 1'b1);
        q.push_back(e);
        m.rbyte(1'b1);
        m.stop();
    endtask
    // ========================================
    // Main sequence
    initial begin
        int bnd;
        logic [7:0] d;
        logic [6:0] ix;
        chip = 3'($random(seed));
        ix = 7'($random(seed));
        d = 8'($random(seed));
        repeat (10) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check("cfg", {8'h00, cfg}, 16'h0000);
        rd1(T_SPC, 16'ha000, 8'h00);
        m.start();
        wb(sel(T_MEM, 1'b0) ^ 8'h02, 1'b0);
        m.stop();
        m.start();
        wb({4'h9, chip, 1'b0}, 1'b0);
        m.stop();
        // Each size code: boundary byte shut; byte below the boundary open for codes 00..10
        for (int bs = 0; bs < 4; bs++) begin
            bnd = 32'hc000 - bs * 32'h4000;
            wr1(T_SPC, {3'h5, 13'($random(seed))}, {4'hf, 1'b1, 2'(bs), 1'b0}, 1'b1);
            check("cfg", {8'h00, cfg}, {12'h000, 1'b1, 2'(bs), 1'b0});
            if (bs < 3) wr1(T_MEM, 16'(bnd - 1), 8'h3c, 1'b1);
            wr1(T_MEM, 16'(bnd), 8'hc3, 1'b0);
        end
        wr1(T_SPC, 16'ha000, 8'h06, 1'b1);
        wr1(T_MEM, 16'hffff, 8'h11, 1'b1);
        inh = 1'b1;
        wr1(T_SPC, 16'ha000, 8'h08, 1'b0);
        wr1(T_MEM, 16'h0000, 8'h22, 1'b0);
        inh = 1'b0;
        bnd = n_wc;
        hdr(T_SPC, 16'hb123);
        wb(8'h08, 1'b1);
        wb(8'h0a, 1'b1);
        m.stop();
        check("wcyc", 16'(n_wc - bnd), 16'h0000);
        check("cfg", {8'h00, cfg}, 16'h0006);
        rd1(T_SPC, {8'h1f, 1'b0, ix}, IDP_BLANK);
        wr1(T_SPC, {3'h0, 5'($random(seed)), 1'b1, ix}, d, 1'b1);
        rd1(T_SPC, {8'h00, 1'b0, ix}, d);
        idp_lk = 1'b1;
        wr1(T_SPC, {8'h00, 1'b0, ix}, ~d, 1'b0);
        rd1(T_SPC, {8'h00, 1'b0, ix}, d);
        idp_lk = 1'b0;
        rd1(T_MEM, 16'h1234, 8'h6e);
        wr1(T_SPC, 16'ha000, 8'h01, 1'b1);
        wr1(T_SPC, 16'ha000, 8'h08, 1'b0);
        check("cfg", {8'h00, cfg}, 16'h0001);
        // Power-up restore of the stored bits
        nv = 4'h6;
        srst_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check("cfg", {8'h00, cfg}, 16'h0006);
        conclude();
    end
endmodule
